// ==== logic/expander_host_pkg.sv ====
// Purpose: Shared constants and types for the port expander bus master.
// Assumes: System clock of 10 MHz; the master makes the serial clock.
// Notes:   Times are kept in ns and turned into cycle counts here.
package expander_host_pkg;

	localparam int unsigned CLK_PERIOD_NS = 100;

	// Quarter of a serial bit; low and high phases are two quarters each
	localparam int unsigned T_QUARTER_NS = 700;
	localparam int unsigned QUARTER_CYC =
		(T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Least wait after the last acknowledge before port data is trusted
	localparam int unsigned OUTPUT_VALID_DELAY_NS = 4000;
	localparam int unsigned OUTPUT_VALID_DELAY_CYC =
		(OUTPUT_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] PV_LOAD = 7'(OUTPUT_VALID_DELAY_CYC);

	localparam logic [3:0] ADDR_FIXED = 4'h4;
	localparam logic [3:0] ACK_BIT    = 4'h8;
	localparam logic [3:0] FIRST_BIT  = 4'h0;

	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_LOW  = 2'h1;
	localparam logic [1:0] BYTE_HIGH = 2'h2;

	localparam logic [1:0] PH_0 = 2'h0;
	localparam logic [1:0] PH_1 = 2'h1;
	localparam logic [1:0] PH_2 = 2'h2;
	localparam logic [1:0] PH_3 = 2'h3;

	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ  = 1'b1;

	localparam logic [7:0] AGE_MAX = 8'hFF;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_BIT   = 5'h04,
		ST_STOP  = 5'h08,
		ST_WAIT  = 5'h10
	} state_e;

endpackage

// ==== logic/quarter_tick.sv ====
// Purpose: Quarter-bit timing strobe for the serial clock divider.
// Assumes: run_in comes from logic on the same clock.
// Notes:   Count restarts while run_in is low, so every frame starts aligned.
`timescale 1ns/1ps
`default_nettype none
module quarter_tick #(
	parameter int unsigned QUARTER = 7
) (
	// Clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	// Control
	input  wire logic run_in,
	// Strobe
	output logic      tick_out
);
	localparam int unsigned CW = $clog2(QUARTER + 1);
	localparam logic [CW-1:0] LAST = CW'(QUARTER - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} tick_s;

	tick_s t_q;
	tick_s t_d;

	always_comb begin
		t_d = t_q;
		t_d.tick = 1'b0;
		if (!run_in) begin
			t_d.cnt = '0;
		end else if (t_q.cnt == LAST) begin
			t_d.cnt = '0;
			t_d.tick = 1'b1;
		end else begin
			t_d.cnt = t_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign tick_out = t_q.tick;

endmodule
`default_nettype wire

// ==== logic/expander_host.sv ====
// Purpose: Bus master that writes and reads a 16-bit port expander.
// Assumes: Master makes the serial clock by division; the slave never
//          stretches it. Pins are open drain: an enable pulls low.
// Notes:   One command moves one byte pair: low port, then high port.
//
// What this block does
// - Start: data falls while clock high.
// - Address byte MSB first, direction bit last.
// - Address select pins held from start to stop.
// - Data stable while clock high.
// - Stop: data rises while clock high.
// - Exactly one acknowledge after every byte.
// - Transmitter releases data before acknowledge.
// - Master acknowledges every read byte but last.
// - Master ends read with not-acknowledge.
// - Address is 0100 then three select pins.
// - Pair order: low port first, high second.
// - Write ones before using bits as inputs; left to the caller, the block drives only what cmd_wdata_in holds.
`timescale 1ns/1ps
`default_nettype none
module expander_host #(
	parameter int unsigned QUARTER_P = expander_host_pkg::QUARTER_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Command
	input  wire logic        cmd_valid_in,
	input  wire logic        cmd_read_in,
	input  wire logic [2:0]  cmd_addr_sel_in,
	input  wire logic [15:0] cmd_wdata_in,
	output logic             cmd_ready_out,
	// Response
	output logic             rsp_valid_out,
	output logic             rsp_nack_out,
	output logic [15:0]      rsp_rdata_out,
	// Serial clock pin
	output logic             scl_out,
	output logic             scl_oe_out,
	// Serial data pin
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	// Strap and interrupt pins
	output logic [2:0]       hw_addr_sel_out,
	input  wire logic        int_n_in,
	output logic             int_pending_out
);
	import expander_host_pkg::*;

	typedef struct packed {
		state_e      st;
		logic [1:0]  ph;
		logic [3:0]  bit_n;
		logic [1:0]  byte_n;
		logic        dir;
		logic [2:0]  sel;
		logic [7:0]  sh;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        nack;
		logic        sda_oe;
		logic        scl_oe;
		logic        pin_lvl;
		logic        sda_m;
		logic        sda_s;
		logic        int_m;
		logic        int_s;
		logic        ready;
		logic        rsp_valid;
		logic [6:0]  pv_cnt;
		logic        int_pend;
		logic [7:0]  age;
	} ctl_s;

	ctl_s s_q;
	ctl_s s_d;
	logic tick;
	logic xmit;
	logic pv_arm;

	quarter_tick #(
		.QUARTER (QUARTER_P)
	) u_tick (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.run_in     (s_q.st != ST_IDLE),
		.tick_out   (tick)
	);

	// The master owns the data line for the address and written bytes
	assign xmit = (s_q.byte_n == BYTE_ADDR) || (s_q.dir == DIR_WRITE);

	// Rising clock of the high byte's acknowledge on a write
	assign pv_arm = (s_q.st == ST_BIT) && tick && (s_q.ph == PH_1) &&
		(s_q.bit_n == ACK_BIT) && (s_q.byte_n == BYTE_HIGH) &&
		(s_q.dir == DIR_WRITE);

	always_comb begin
		s_d = s_q;
		// Only the second stage is read; the first may be metastable
		s_d.sda_m = sda_in;
		s_d.sda_s = s_q.sda_m;
		s_d.int_m = int_n_in;
		s_d.int_s = s_q.int_m;
		s_d.int_pend = ~s_q.int_s;
		s_d.pin_lvl = 1'b0;
		s_d.rsp_valid = 1'b0;
		if (s_q.pv_cnt != '0) begin
			s_d.pv_cnt = s_q.pv_cnt - 1'b1;
		end
		// Cycles since the write's last acknowledge rose, saturating
		if (pv_arm) begin
			s_d.age = '0;
		end else if (s_q.age != AGE_MAX) begin
			s_d.age = s_q.age + 1'b1;
		end
		case (s_q.st)
			ST_IDLE: begin
				s_d.ph = PH_0;
				s_d.sda_oe = 1'b0;
				s_d.scl_oe = 1'b0;
				if (cmd_valid_in) begin
					s_d.st = ST_START;
					s_d.dir = cmd_read_in;
					s_d.sel = cmd_addr_sel_in;
					s_d.wdata = cmd_wdata_in;
					s_d.nack = 1'b0;
				end
			end
			ST_START: begin
				if (tick) begin
					s_d.ph = s_q.ph + 1'b1;
					case (s_q.ph)
						PH_2: begin
							s_d.sda_oe = 1'b1;
						end
						PH_3: begin
							s_d.scl_oe = 1'b1;
							s_d.st = ST_BIT;
							s_d.bit_n = FIRST_BIT;
							s_d.byte_n = BYTE_ADDR;
							s_d.sh = {ADDR_FIXED, s_q.sel, s_q.dir};
						end
						default: begin
						end
					endcase
				end
			end
			ST_BIT: begin
				if (tick) begin
					s_d.ph = s_q.ph + 1'b1;
					case (s_q.ph)
						PH_0: begin
							// Clock is low here, so the data line may move
							if (s_q.bit_n != ACK_BIT) begin
								s_d.sda_oe = xmit ? ~s_q.sh[7] : 1'b0;
							end else if (xmit) begin
								s_d.sda_oe = 1'b0;
							end else begin
								// Acknowledge the low byte, refuse the last
								s_d.sda_oe = (s_q.byte_n == BYTE_LOW);
							end
						end
						PH_1: begin
							s_d.scl_oe = 1'b0;
							if (pv_arm) begin
								s_d.pv_cnt = PV_LOAD;
							end
						end
						PH_2: begin
							if (s_q.bit_n != ACK_BIT) begin
								// Shifting the line in also shifts sent bits out
								s_d.sh = {s_q.sh[6:0], s_q.sda_s};
							end else if (xmit) begin
								s_d.nack = s_q.sda_s;
							end
						end
						PH_3: begin
							s_d.scl_oe = 1'b1;
							if (s_q.bit_n != ACK_BIT) begin
								s_d.bit_n = s_q.bit_n + 1'b1;
							end else if (xmit && s_q.nack) begin
								// Nobody answered; close the frame at once
								s_d.st = ST_STOP;
							end else begin
								s_d.bit_n = FIRST_BIT;
								case (s_q.byte_n)
									BYTE_ADDR: begin
										s_d.byte_n = BYTE_LOW;
										s_d.sh = s_q.wdata[7:0];
									end
									BYTE_LOW: begin
										s_d.byte_n = BYTE_HIGH;
										s_d.sh = s_q.wdata[15:8];
										if (s_q.dir == DIR_READ) begin
											s_d.rdata[7:0] = s_q.sh;
										end
									end
									default: begin
										s_d.st = ST_STOP;
										if (s_q.dir == DIR_READ) begin
											s_d.rdata[15:8] = s_q.sh;
										end
									end
								endcase
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_STOP: begin
				if (tick) begin
					s_d.ph = s_q.ph + 1'b1;
					case (s_q.ph)
						PH_0: begin
							s_d.sda_oe = 1'b1;
						end
						PH_1: begin
							s_d.scl_oe = 1'b0;
						end
						PH_3: begin
							s_d.sda_oe = 1'b0;
							s_d.st = ST_WAIT;
						end
						default: begin
						end
					endcase
				end
			end
			ST_WAIT: begin
				// Report a write only once the port pins can be trusted
				if (s_q.pv_cnt == '0) begin
					s_d.st = ST_IDLE;
					s_d.rsp_valid = 1'b1;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
				s_d.sda_oe = 1'b0;
				s_d.scl_oe = 1'b0;
			end
		endcase
		s_d.ready = (s_d.st == ST_IDLE) && !s_d.rsp_valid;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_ready_out   = s_q.ready;
	assign rsp_valid_out   = s_q.rsp_valid;
	assign rsp_nack_out    = s_q.nack;
	assign rsp_rdata_out   = s_q.rdata;
	assign scl_out         = s_q.pin_lvl;
	assign scl_oe_out      = s_q.scl_oe;
	assign sda_out         = s_q.pin_lvl;
	assign sda_oe_out      = s_q.sda_oe;
	assign hw_addr_sel_out = s_q.sel;
	assign int_pending_out = s_q.int_pend;

	default clocking cb @(posedge clk_sys_in);
	endclocking

	default disable iff (!rst_n_in);

	a_start_only: assert property (
		$rose(sda_oe_out) && !scl_oe_out |-> s_q.st == ST_START)
		else $error("data fell under a high clock outside a start");

	a_stop_only: assert property (
		$fell(sda_oe_out) && !scl_oe_out |-> s_q.st == ST_WAIT)
		else $error("data rose under a high clock outside a stop");

	a_data_stable: assert property (
		s_q.st == ST_BIT && !scl_oe_out && !$past(scl_oe_out)
		|-> $stable(sda_oe_out))
		else $error("data line moved while the clock was high");

	a_addr_byte: assert property (
		$rose(s_q.st == ST_BIT)
		|-> s_q.sh == {ADDR_FIXED, hw_addr_sel_out, s_q.dir})
		else $error("address byte does not carry 0100, select and direction");

	a_sel_hold: assert property (
		!cmd_ready_out && !$past(cmd_ready_out)
		|-> $stable(hw_addr_sel_out))
		else $error("address select pins moved during a transfer");

	a_release_ack: assert property (
		s_q.st == ST_BIT && s_q.bit_n == ACK_BIT && xmit && s_q.ph != PH_0
		|-> !sda_oe_out)
		else $error("master still drives data in the slave's acknowledge");

	a_read_ack: assert property (
		s_q.st == ST_BIT && s_q.bit_n == ACK_BIT && !xmit &&
		s_q.byte_n == BYTE_LOW && s_q.ph != PH_0 |-> sda_oe_out)
		else $error("first read byte was not acknowledged");

	a_read_nack: assert property (
		s_q.st == ST_BIT && s_q.bit_n == ACK_BIT && !xmit &&
		s_q.byte_n == BYTE_HIGH && s_q.ph != PH_0 |-> !sda_oe_out)
		else $error("last read byte was acknowledged");

	a_pv_wait: assert property (
		rsp_valid_out && !rsp_nack_out && s_q.dir == DIR_WRITE
		|-> s_q.age >= 8'(OUTPUT_VALID_DELAY_CYC))
		else $error("write reported before the output valid delay");

	a_one_ack: assert property (
		s_q.st == ST_BIT |-> s_q.bit_n <= ACK_BIT)
		else $error("more than eight bits before an acknowledge");

	a_nack_stop: assert property (
		s_q.st == ST_BIT && tick && s_q.ph == PH_3 &&
		s_q.bit_n == ACK_BIT && xmit && s_q.nack
		|=> s_q.st == ST_STOP ##1 s_q.sda_oe == 1'b0 [*2])
		else $error("refused byte did not lead to a stop");

	c_write_done: cover property (
		rsp_valid_out && !rsp_nack_out && s_q.dir == DIR_WRITE);

	c_read_done: cover property (
		rsp_valid_out && !rsp_nack_out && s_q.dir == DIR_READ);

	c_addr_nack: cover property (
		rsp_valid_out && rsp_nack_out && s_q.byte_n == BYTE_ADDR);

	c_back_to_back: cover property (
		rsp_valid_out ##1 cmd_valid_in && cmd_ready_out);

endmodule
`default_nettype wire

// ==== tb/expander_slave_model.sv ====
// Purpose: Behavioural model of the 16-bit port expander slave.
// Assumes: Lines are open drain with pull-ups resolved by the bench.
// Notes:   Runs on the serial clock only and never stretches it.
`timescale 1ns/1ps
`default_nettype none
module expander_slave_model (
	// Reset and straps
	input  wire logic        rst_n_in,
	input  wire logic [2:0]  strap_in,
	// Serial lines
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_oe_out,
	// Port pins
	input  wire logic [15:0] pins_in,
	output logic [15:0]      port_out,
	output logic [15:0]      boost_out,
	output logic             int_n_out
);
	logic [3:0] cnt;
	logic [1:0] mode;
	logic       hi;
	logic [7:0] sh;
	logic [7:0] rd;
	logic [7:0] lo;

	task automatic clear;
		port_out = 16'hFFFF;
		boost_out = 16'h0000;
		int_n_out = 1'b1;
		sda_oe_out = 1'b0;
		mode = 2'h0;
	endtask

	initial clear();
	always @(negedge rst_n_in) clear();

	always @(pins_in) if (rst_n_in === 1'b1) begin
		int_n_out = 1'b0;
	end

	// Mode 0 idle, 1 address, 2 write, 3 read
	always @(negedge sda_in) if (scl_in === 1'b1 && rst_n_in) begin
		mode = 2'h1;
		cnt = 4'h0;
		hi = 1'b0;
		sda_oe_out = 1'b0;
	end

	always @(posedge sda_in) if (scl_in === 1'b1) begin
		mode = 2'h0;
		sda_oe_out = 1'b0;
	end

	// Counted on rising clocks, so the start's own clock fall is no bit
	always @(posedge scl_in) if (mode != 2'h0) begin
		if (cnt != 4'h8) begin
			sh = {sh[6:0], sda_in};
		end else begin
			int_n_out = 1'b1;
			if (mode == 2'h1) begin
				mode = sh[0] ? 2'h3 : 2'h2;
			end else if (mode == 2'h2) begin
				if (hi) begin
					port_out = {sh, lo};
					boost_out = {sh, lo};
				end else begin
					lo = sh;
				end
				hi = ~hi;
			end else if (sda_in) begin
				mode = 2'h0;
			end else begin
				hi = ~hi;
			end
		end
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end

	// Drive changes only while the clock is low
	always @(negedge scl_in) begin
		boost_out = 16'h0000;
		if (mode != 2'h0) begin
			sda_oe_out = 1'b0;
			if (cnt == 4'h8) begin
				if (mode == 2'h1 && sh[7:1] != {4'h4, strap_in})
					mode = 2'h0;
				else if (mode != 2'h3)
					sda_oe_out = 1'b1;
			end else if (mode == 2'h3) begin
				if (cnt == 4'h0)
					rd = hi ? pins_in[15:8] : pins_in[7:0];
				else
					rd = {rd[6:0], 1'b0};
				sda_oe_out = ~rd[7];
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/expander_host_tb.sv ====
// Purpose: Self-checking bench for the port expander bus master.
// Assumes: Slave model on the far side; pull-ups on both lines.
// Notes:   Start and stop counts are taken on the wires themselves.
`timescale 1ns/1ps
`default_nettype none
module expander_host_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_read = 1'b0;
	logic [2:0]  cmd_sel = 3'h0;
	logic [2:0]  flip = 3'h0;
	logic [15:0] cmd_wdata = 16'h0000;
	logic [15:0] pins = 16'h0000;
	wire         cmd_ready, rsp_valid, rsp_nack, scl_oe, sda_oe;
	wire         slv_oe, int_n, int_pending;
	wire  [15:0] rdata, port;
	wire  [2:0]  hw_sel;
	wire  [15:0] boost;
	wire         scl_lvl, sda_lvl;
	// Open drain: an enabled driver shows its level, else the pull-up wins
	wire         scl = scl_oe ? scl_lvl : 1'b1;
	wire         sda = (sda_oe ? sda_lvl : 1'b1) & ~slv_oe;
	int          fails = 0;
	int          checks_done = 0;
	int          starts = 0;
	int          stops = 0;

	always #50 clk = ~clk;
	always @(negedge sda) if (scl === 1'b1) starts++;
	always @(posedge sda) if (scl === 1'b1) stops++;

	expander_host DUT (
		.clk_sys_in(clk), .rst_n_in(rst_n),
		.cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read),
		.cmd_addr_sel_in(cmd_sel), .cmd_wdata_in(cmd_wdata),
		.cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
		.rsp_nack_out(rsp_nack), .rsp_rdata_out(rdata),
		.scl_out(scl_lvl), .scl_oe_out(scl_oe), .sda_in(sda),
		.sda_out(sda_lvl),
		.sda_oe_out(sda_oe), .hw_addr_sel_out(hw_sel),
		.int_n_in(int_n), .int_pending_out(int_pending)
	);

	// Strap mismatch is made by flipping bits between host and slave
	expander_slave_model slave (
		.rst_n_in(rst_n), .strap_in(hw_sel ^ flip), .scl_in(scl),
		.sda_in(sda), .sda_oe_out(slv_oe), .pins_in(pins),
		.port_out(port), .boost_out(boost), .int_n_out(int_n)
	);

	task automatic print_verdict;
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic xfer(input logic rd, input logic [2:0] sel,
			input logic [15:0] wd);
		int n;
		int s0;
		int p0;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		s0 = starts;
		p0 = stops;
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_sel = sel;
		cmd_wdata = wd;
		tick(1);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		if (n >= 3000) begin
			fails++;
			print_verdict();
		end
		chk(16'(starts - s0), 16'h1);
		chk(16'(stops - p0), 16'h1);
	endtask

	task automatic s_reset;
		chk(16'(cmd_ready), 16'h1);
		chk(16'({scl, sda}), 16'h3);
		chk(port, 16'hFFFF);
		chk(16'(int_pending), 16'h0);
	endtask

	task automatic s_writes;
		logic [15:0] wd;
		for (int i = 0; i < 8; i++) begin
			wd = {5'h1F ^ 5'(i), 3'(i), 8'h5A ^ 8'(i)};
			xfer(1'b0, 3'(i), wd);
			chk(16'(hw_sel), 16'(i));
			chk(16'(rsp_nack), 16'h0);
			chk(port, wd);
			chk(boost, 16'h0000);
		end
	endtask

	task automatic s_nack;
		flip = 3'h5;
		xfer(1'b0, 3'h2, 16'h0000);
		chk(16'(rsp_nack), 16'h1);
		chk(port, 16'hC75D);
		flip = 3'h0;
	endtask

	task automatic s_read;
		xfer(1'b0, 3'h1, 16'hFFFF);
		pins = 16'h3CC3;
		tick(8);
		chk(16'(int_pending), 16'h1);
		xfer(1'b1, 3'h1, 16'h0000);
		chk(rdata, 16'h3CC3);
		chk(16'(rsp_nack), 16'h0);
		tick(8);
		chk(16'(int_pending), 16'h0);
		chk(16'({scl, sda}), 16'h3);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		tick(4);
		s_reset();
		s_writes();
		s_nack();
		s_read();
		print_verdict();
	end
endmodule
`default_nettype wire
